// file: rtl/lipr_pkg.sv
// Constants and types for the light intensity PWM regulator
package lipr_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_LIGHT_SOURCE_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_INITIAL_DUTY_VALUE  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_AMP_LOWER_LIMIT     = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_AMP_UPPER_LIMIT     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS              = 8'h10;

  // Field positions in light_source_config
  localparam int CFG_EN_BIT    = 0;
  localparam int CFG_AUTO_BIT  = 1;
  localparam int CFG_ODRAIN_BIT = 2;
  localparam int CFG_POL_BIT   = 3;
  localparam int CFG_FREQ_LSB  = 4;
  localparam int CFG_BUF_LSB   = 8;

  // Field widths
  localparam int FREQ_W = 2;
  localparam int BUF_W  = 3;
  localparam int DUTY_W = 8;
  localparam int AMP_W  = 8;
  localparam int CMP_W  = 10;

  // Field positions in status
  localparam int STS_DUTY_LSB = 0;
  localparam int STS_ACT_BIT  = 8;
  localparam int STS_MODE_BIT = 9;
  localparam int STS_LED_BIT  = 10;

  // Reset values
  localparam logic [DUTY_W-1:0] INIT_DUTY_RST = 8'h80;
  localparam logic [AMP_W-1:0]  AMP_LO_RST    = 8'h87;
  localparam logic [AMP_W-1:0]  AMP_HI_RST    = 8'hA5;
  localparam logic [FREQ_W-1:0] FREQ_RST      = 2'h3;
  localparam logic [BUF_W-1:0]  BUF_RST       = 3'h0;
  localparam logic              POL_RST       = 1'b1;

  // Duty limits and buffer code 0 substitute
  localparam logic [DUTY_W-1:0] DUTY_MIN  = 8'h00;
  localparam logic [DUTY_W-1:0] DUTY_MAX  = 8'hFF;
  localparam logic [CMP_W-1:0]  BUF_ZERO_EFF = 10'h008;

  // Timing: regulation rate and clock
  localparam int CLOCK_HZ    = 200_000_000;
  localparam int REG_RATE_HZ = 500;
  localparam int TICK_CYCLES = CLOCK_HZ / REG_RATE_HZ;
  localparam int TICK_W      = 20;

  // PWM prescaler: code 3 divides the clock by 8, each lower code doubles it
  localparam int PRE_W = 7;
  localparam logic [PRE_W-1:0] PRE_BASE = 7'h08;
  localparam logic [FREQ_W-1:0] FREQ_TOP = 2'h3;

  // Regulator state, one-hot
  typedef enum logic [1:0] {
    ST_HOLD     = 2'b01,
    ST_REGULATE = 2'b10
  } lipr_state_t;

endpackage

// file: rtl/lipr_regulator.sv
// Light source intensity regulator with PWM output and register port
//
// Notes on behaviour
// - Regulation runs only in serial configuration mode, driven by the amplitude.
// - Pin driven only when output enabled; duty stepped only with automatic mode.
// - Before regulation, the duty is loaded from the initial duty value.
// - On-time ratio equals duty divided by 256.
// - While regulating, duty moves by at most one step per 500 Hz tick.
// - Band is centred between limits, width upper minus lower minus twice buffer.
// - Buffer code 0 acts as a buffer of 8 counts.
// - Output type 1 gives open-drain, 0 gives push-pull.
// - Output polarity is selectable for direct LED or transistor drive.
// - Frequency code selects PWM rate; code 3 gives 97.6 kHz.
// - Lower and upper limits are the amplitude monitor limits.
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module lipr_regulator
  import lipr_pkg::*;
#(
  parameter int TICK_PERIOD = TICK_CYCLES
)
(
  input  wire logic                          clock,
  input  wire logic                          rst_b,
  input  wire logic [lipr_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [lipr_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [lipr_pkg::DATA_W-1:0]   reg_rdata,
  input  wire logic                          serial_config_mode,
  input  wire logic [lipr_pkg::AMP_W-1:0]    sincos_amplitude,
  output logic                               led_out,
  output logic                               led_oe,
  output logic      [lipr_pkg::DUTY_W-1:0]   duty_value
);
  import lipr_pkg::*;

  // Last count of the regulation tick; the parameter lets a test shorten it
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_PERIOD - 1);

  // Whole module state
  // One struct keeps reset, next-state and register in step
  typedef struct packed {
    logic                light_output_enable;
    logic                automatic_intensity_enable;
    logic                output_type_select;
    logic                output_polarity;
    logic [FREQ_W-1:0]   pwm_frequency_select;
    logic [BUF_W-1:0]    hysteresis_buffer_zone;
    logic [DUTY_W-1:0]   initial_duty_value;
    logic [AMP_W-1:0]    amplitude_lower_limit;
    logic [AMP_W-1:0]    amplitude_upper_limit;
    logic [2:0]          mode_sync;
    logic                mode;
    lipr_state_t         state;
    logic [DUTY_W-1:0]   duty;
    logic [TICK_W-1:0]   tick_cnt;
    logic [PRE_W-1:0]    pre_cnt;
    logic [DUTY_W-1:0]   phase;
    logic                led_out;
    logic                led_oe;
    logic [DATA_W-1:0]   rdata;
  } lipr_regs_t;

  lipr_regs_t r_q;
  lipr_regs_t r_d;

  // Combinational helpers
  // Band compare, tick and PWM level are plain decode of the state and the amplitude input
  logic [CMP_W-1:0]   buf_eff;
  logic [CMP_W-1:0]   low_thr;
  logic [CMP_W-1:0]   high_thr;
  logic [CMP_W-1:0]   amp_ext;
  logic               below_band;
  logic               above_band;
  logic               active;
  logic               tick;
  logic [PRE_W-1:0]   pre_last;
  logic               pwm_on;
  logic               level;
  logic [DATA_W-1:0]  cfg_word;
  logic [DATA_W-1:0]  sts_word;

  // Band thresholds in 10 bits so the sums cannot overflow the 8-bit limits
  // Lower edge is lower limit plus buffer, upper edge is upper limit minus buffer
  // Buffer code 0 stands for 8 counts, every other code for itself
  // The subtraction wraps if software sets the buffer above the upper limit; the upper edge then lies above any amplitude, so duty never steps down
  // Amplitude is on this clock already, so it is used without a synchroniser
  always_comb
  begin
    buf_eff = (r_q.hysteresis_buffer_zone == BUF_W'(0))
              ? BUF_ZERO_EFF
              : CMP_W'(r_q.hysteresis_buffer_zone);
    low_thr  = CMP_W'(r_q.amplitude_lower_limit) + buf_eff;
    high_thr = CMP_W'(r_q.amplitude_upper_limit) - buf_eff;
    amp_ext  = CMP_W'(sincos_amplitude);
    below_band = amp_ext < low_thr;
    above_band = amp_ext > high_thr;
  end

  // Regulation is live only with all three conditions
  // Mode is the synchronised copy, so entry lags the pin by three or four cycles
  assign active = r_q.mode && r_q.light_output_enable
                  && r_q.automatic_intensity_enable;

  // Tick is free running from reset, so the first step after entering
  // regulation lands anywhere up to one full tick period later
  assign tick = (r_q.tick_cnt == TICK_LAST);

  // Prescale terminal count halves per frequency code step
  assign pre_last = PRE_W'((PRE_BASE << (FREQ_TOP - r_q.pwm_frequency_select)) - 1);

  // High for duty out of 256 phase counts
  // Duty 255 is the brightest setting: the pin is never on for all 256 counts
  assign pwm_on = (r_q.phase < r_q.duty);

  // Active level follows the polarity bit
  assign level = r_q.output_polarity ? pwm_on : !pwm_on;

  // Read views
  always_comb
  begin
    cfg_word = '0;
    cfg_word[CFG_EN_BIT]     = r_q.light_output_enable;
    cfg_word[CFG_AUTO_BIT]   = r_q.automatic_intensity_enable;
    cfg_word[CFG_ODRAIN_BIT] = r_q.output_type_select;
    cfg_word[CFG_POL_BIT]    = r_q.output_polarity;
    cfg_word[CFG_FREQ_LSB +: FREQ_W] = r_q.pwm_frequency_select;
    cfg_word[CFG_BUF_LSB +: BUF_W]   = r_q.hysteresis_buffer_zone;
    sts_word = '0;
    sts_word[STS_DUTY_LSB +: DUTY_W] = r_q.duty;
    sts_word[STS_ACT_BIT]  = (r_q.state == ST_REGULATE);
    sts_word[STS_MODE_BIT] = r_q.mode;
    sts_word[STS_LED_BIT]  = r_q.led_out;
  end

  // Next state of everything
  // Every field defaults to its current value, so unlisted fields hold
  always_comb
  begin
    r_d = r_q;

    // Register writes
    if (reg_wr)
    begin
      case (reg_addr)
        OFS_LIGHT_SOURCE_CONFIG:
        begin
          r_d.light_output_enable        = reg_wdata[CFG_EN_BIT];
          r_d.automatic_intensity_enable = reg_wdata[CFG_AUTO_BIT];
          r_d.output_type_select         = reg_wdata[CFG_ODRAIN_BIT];
          r_d.output_polarity            = reg_wdata[CFG_POL_BIT];
          r_d.pwm_frequency_select       = reg_wdata[CFG_FREQ_LSB +: FREQ_W];
          r_d.hysteresis_buffer_zone     = reg_wdata[CFG_BUF_LSB +: BUF_W];
        end
        OFS_INITIAL_DUTY_VALUE: r_d.initial_duty_value    = reg_wdata[DUTY_W-1:0];
        OFS_AMP_LOWER_LIMIT:    r_d.amplitude_lower_limit = reg_wdata[AMP_W-1:0];
        OFS_AMP_UPPER_LIMIT:    r_d.amplitude_upper_limit = reg_wdata[AMP_W-1:0];
        default: ;
      endcase
    end

    // Read data stands only in the cycle after the strobe
    r_d.rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_LIGHT_SOURCE_CONFIG: r_d.rdata = cfg_word;
        OFS_INITIAL_DUTY_VALUE:  r_d.rdata = DATA_W'(r_q.initial_duty_value);
        OFS_AMP_LOWER_LIMIT:     r_d.rdata = DATA_W'(r_q.amplitude_lower_limit);
        OFS_AMP_UPPER_LIMIT:     r_d.rdata = DATA_W'(r_q.amplitude_upper_limit);
        OFS_STATUS:              r_d.rdata = sts_word;
        default:                 r_d.rdata = '0;
      endcase
    end

    // Mode pin: three stages, a change counts once the last two agree
    // First stage may go metastable; only the shift reads it
    // The agree test also rejects a one-cycle glitch on the pin
    r_d.mode_sync = {r_q.mode_sync[1:0], serial_config_mode};
    if (r_q.mode_sync[2] == r_q.mode_sync[1])
    begin
      r_d.mode = r_q.mode_sync[2];
    end

    // Free running 500 Hz tick counter
    // Default period gives one tick every two milliseconds
    r_d.tick_cnt = tick ? '0 : r_q.tick_cnt + TICK_W'(1);

    // Regulator state machine
    // Leaving regulation reloads the start duty, so the learned value is lost
    case (r_q.state)
      ST_HOLD:
      begin
        // Track the start value so regulation begins from it
        r_d.duty = r_q.initial_duty_value;
        if (active)
        begin
          r_d.state = ST_REGULATE;
        end
      end
      ST_REGULATE:
      begin
        if (!active)
        begin
          r_d.state = ST_HOLD;
        end
        else if (tick)
        begin
          // One step per tick, clamped at the ends
          if (below_band && r_q.duty != DUTY_MAX)
          begin
            r_d.duty = r_q.duty + DUTY_W'(1);
          end
          else if (above_band && r_q.duty != DUTY_MIN)
          begin
            r_d.duty = r_q.duty - DUTY_W'(1);
          end
        end
      end
      default:
      begin
        r_d.state = ST_HOLD;
      end
    endcase

    // PWM timebase: prescaler then 256 phase steps
    // The greater-or-equal test recovers at once when a faster code cuts the count
    // Prescale doubles per lower code, so code 3 gives 2048 clocks a period
    if (r_q.pre_cnt >= pre_last)
    begin
      r_d.pre_cnt = '0;
      r_d.phase   = r_q.phase + DUTY_W'(1);
    end
    else
    begin
      r_d.pre_cnt = r_q.pre_cnt + PRE_W'(1);
    end

    // Pin drive; open-drain only ever pulls low
    // Open-drain releases the pin for the high level and lets the pull-up lift it
    // Disabled output releases the pin entirely and holds the data bit low
    if (!r_q.light_output_enable)
    begin
      r_d.led_out = 1'b0;
      r_d.led_oe  = 1'b0;
    end
    else if (r_q.output_type_select)
    begin
      r_d.led_out = 1'b0;
      r_d.led_oe  = !level;
    end
    else
    begin
      r_d.led_out = level;
      r_d.led_oe  = 1'b1;
    end
  end

  // State register with synchronous reset
  // Reset values match the read view of an untouched block
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      r_q.light_output_enable        <= 1'b0;
      r_q.automatic_intensity_enable <= 1'b0;
      r_q.output_type_select         <= 1'b0;
      r_q.output_polarity            <= POL_RST;
      r_q.pwm_frequency_select       <= FREQ_RST;
      r_q.hysteresis_buffer_zone     <= BUF_RST;
      r_q.initial_duty_value         <= INIT_DUTY_RST;
      r_q.amplitude_lower_limit      <= AMP_LO_RST;
      r_q.amplitude_upper_limit      <= AMP_HI_RST;
      r_q.mode_sync                  <= '0;
      r_q.mode                       <= 1'b0;
      r_q.state                      <= ST_HOLD;
      r_q.duty                       <= INIT_DUTY_RST;
      r_q.tick_cnt                   <= '0;
      r_q.pre_cnt                    <= '0;
      r_q.phase                      <= '0;
      r_q.led_out                    <= 1'b0;
      r_q.led_oe                     <= 1'b0;
      r_q.rdata                      <= '0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // Outputs straight from flops, so the pin sees no combinational glitch
  // Duty is exported for monitoring beside the status read
  assign reg_rdata  = r_q.rdata;
  assign led_out    = r_q.led_out;
  assign led_oe     = r_q.led_oe;
  assign duty_value = r_q.duty;

endmodule

`default_nettype wire

// file: tb/lipr_checker.sv
// Port assertions for the light intensity regulator
`timescale 1ns/1ps
`default_nettype none

module lipr_checker
  import lipr_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        rst_b,
  input  wire logic [lipr_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [lipr_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [lipr_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                        serial_config_mode,
  input  wire logic                        led_out,
  input  wire logic                        led_oe,
  input  wire logic [lipr_pkg::DUTY_W-1:0] duty_value
);
  logic       en_q, auto_q, od_q, pol_q;
  logic [7:0] init_q;
  logic       act;

  // Shadow of the written settings; the unsynced mode makes act lead the design
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      {pol_q, od_q, auto_q, en_q} <= 4'h8;
      init_q <= INIT_DUTY_RST;
    end
    else if (reg_wr && reg_addr == OFS_LIGHT_SOURCE_CONFIG)
      {pol_q, od_q, auto_q, en_q} <= reg_wdata[3:0];
    else if (reg_wr && reg_addr == OFS_INITIAL_DUTY_VALUE)
      init_q <= reg_wdata[7:0];
  end
  assign act = en_q && auto_q && serial_config_mode;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // Settled windows, long enough to cover the mode synchroniser
  sequence settled_act;
    act [*8];
  endsequence
  sequence settled_hold;
    (!act && $stable(init_q)) [*8];
  endsequence

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not zero outside read answer");
  duty_step_a: assert property (settled_act ##0 $changed(duty_value) |->
    (duty_value == $past(duty_value) + 8'h01 || duty_value == $past(duty_value) - 8'h01))
    else $error("duty moved by more than one step");
  duty_hold_a: assert property (settled_hold |-> duty_value == init_q)
    else $error("duty not at initial value outside regulation");
  pp_drive_a: assert property ((en_q && !od_q) [*3] |-> led_oe)
    else $error("push-pull pin not driven");
  od_drive_a: assert property ((en_q && od_q) [*3] |-> !led_out)
    else $error("open-drain pin drives high");
  led_off_a: assert property ((!en_q) [*3] |-> !led_oe && !led_out)
    else $error("pin driven while output disabled");
  dark_zero_a: assert property (
    (en_q && !od_q && duty_value == DUTY_MIN && $stable(pol_q)) [*4] |-> led_out == !pol_q)
    else $error("zero duty shows on-level");
  duty_read_a: assert property ($past(reg_rd && reg_addr == OFS_STATUS) |->
    reg_rdata[7:0] == $past(duty_value))
    else $error("status duty differs from duty output");
endmodule

bind lipr_regulator lipr_checker lipr_checker_inst (.clock(clock), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .serial_config_mode(serial_config_mode), .led_out(led_out),
  .led_oe(led_oe), .duty_value(duty_value));

`default_nettype wire

// file: tb/lipr_led_model.sv
// Light source model on the pin, with pull-up and a lit-cycle counter
`timescale 1ns/1ps
`default_nettype none

module lipr_led_model (
  input  wire logic        clock,
  input  wire logic        led_out,
  input  wire logic        led_oe,
  input  wire logic        clr,
  output logic             pin,
  output logic [15:0]      lit
);
  // A released pin floats up to the pull-up, never to the last value
  assign pin = led_oe ? led_out : 1'b1;

  // High cycles since the last clear; one full PWM period gives an exact count
  always_ff @(posedge clock)
  begin
    if (clr)
      lit <= 16'h0000;
    else if (pin)
      lit <= lit + 16'h0001;
  end
endmodule

`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the light intensity regulator
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s exp %0h got %0h", n, e, g); end end

module testbench;
  import lipr_pkg::*;
  localparam int TP = 50;
  logic        clock = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, mode = 0, clr = 0;
  logic [7:0]  addr = 0, amp = 0, duty;
  logic [31:0] wdata = 0, rdata;
  logic        led_out, led_oe, pin;
  logic [15:0] lit;
  int          fail_count = 0, compares = 0;

  // 200 MHz clock
  always #2.5 clock = ~clock;

  lipr_regulator #(.TICK_PERIOD(TP)) lipr_regulator_inst (.clock(clock), .rst_b(rst_b),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .serial_config_mode(mode), .sincos_amplitude(amp), .led_out(led_out), .led_oe(led_oe),
    .duty_value(duty));
  lipr_led_model lipr_led_model_inst (.clock(clock), .led_out(led_out), .led_oe(led_oe),
    .clr(clr), .pin(pin), .lit(lit));

  // Bus cycles: one strobe cycle each, read data sampled in the answer cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_rd <= 1;
    addr <= a;
    @(posedge clock);
    reg_rd <= 0;
    @(negedge clock);
    `CHK("rdata", e, rdata)
  endtask
  // Over two tick periods exactly one tick lands in the second one
  task automatic reg_step(input logic [7:0] a, input logic [7:0] dl);
    logic [7:0] d0;
    @(posedge clock);
    amp <= a;
    repeat (TP) @(negedge clock);
    d0 = duty;
    repeat (TP) @(negedge clock);
    `CHK("duty step", d0 + dl, duty)
  endtask
  task automatic pwm(input logic [31:0] c, input logic [15:0] n, input logic [15:0] e);
    wr(OFS_LIGHT_SOURCE_CONFIG, c);
    repeat (8) @(posedge clock);
    clr <= 1;
    @(posedge clock);
    clr <= 0;
    repeat (n) @(posedge clock);
    @(negedge clock);
    `CHK("pin high cycles", e, lit)
  endtask

  task automatic t_reset;
    rd(OFS_LIGHT_SOURCE_CONFIG, 32'h0000_0038);
    rd(OFS_INITIAL_DUTY_VALUE, 32'h0000_0080);
    rd(OFS_AMP_LOWER_LIMIT, 32'h0000_0087);
    rd(OFS_AMP_UPPER_LIMIT, 32'h0000_00A5);
    wr(OFS_STATUS, 32'h0000_0000);
    wr(8'h20, 32'h0000_00FF);
    rd(OFS_STATUS, 32'h0000_0080);
    rd(8'h20, 32'h0000_0000);
  endtask
  task automatic t_hold;
    wr(OFS_INITIAL_DUTY_VALUE, 32'h0000_0040);
    repeat (4) @(negedge clock);
    `CHK("duty", 8'h40, duty)
  endtask
  // Duty 0x40 is a quarter on-time; released pins float high to the pull-up
  task automatic t_pwm;
    pwm(32'h0000_0039, 16'h0800, 16'h0200);
    pwm(32'h0000_0031, 16'h0800, 16'h0600);
    pwm(32'h0000_003D, 16'h0800, 16'h0200);
    pwm(32'h0000_0029, 16'h1000, 16'h0400);
    pwm(32'h0000_0019, 16'h2000, 16'h0800);
    pwm(32'h0000_0009, 16'h4000, 16'h1000);
    pwm(32'h0000_0038, 16'h0800, 16'h0800);
  endtask
  // Buffer code 0 acts as 8: thresholds 143 and 157 around the default limits
  task automatic t_regulate;
    @(posedge clock);
    mode <= 1;
    wr(OFS_LIGHT_SOURCE_CONFIG, 32'h0000_003B);
    reg_step(8'h64, 8'h01);
    reg_step(8'h8E, 8'h01);
    reg_step(8'h8F, 8'h00);
    reg_step(8'h9D, 8'h00);
    reg_step(8'h9E, 8'hFF);
    wr(OFS_LIGHT_SOURCE_CONFIG, 32'h0000_023B); // buffer 2 stays below half span
    reg_step(8'h8C, 8'h00);
    @(posedge clock);
    mode <= 0;
    repeat (10) @(negedge clock);
    `CHK("duty", 8'h40, duty)
    reg_step(8'h64, 8'h00);
  endtask
  task automatic t_saturate;
    @(posedge clock);
    mode <= 1;
    wr(OFS_LIGHT_SOURCE_CONFIG, 32'h0000_0039);
    wr(OFS_INITIAL_DUTY_VALUE, 32'h0000_00FF);
    wr(OFS_LIGHT_SOURCE_CONFIG, 32'h0000_003B);
    reg_step(8'h64, 8'h00);
    wr(OFS_LIGHT_SOURCE_CONFIG, 32'h0000_0039);
    wr(OFS_INITIAL_DUTY_VALUE, 32'h0000_0000);
    wr(OFS_LIGHT_SOURCE_CONFIG, 32'h0000_003B);
    reg_step(8'hC8, 8'h00);
    rd(OFS_STATUS, 32'h0000_0300);
    wr(OFS_LIGHT_SOURCE_CONFIG, 32'h0000_0033);
    rd(OFS_STATUS, 32'h0000_0700);
  endtask

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Reset for three cycles, then the scenarios in order
  initial
  begin
    repeat (3) @(posedge clock);
    rst_b <= 1;
    t_reset;
    t_hold;
    t_pwm;
    t_regulate;
    t_saturate;
    results;
  end
endmodule

`undef CHK
`default_nettype wire
